// file: hw/wtccr_pkg.sv
/*
 * Package for the waveform timer capture/compare register block: offsets, fields, resets.
 * Assumes a byte-wide register port with byte offsets as printed.
 */
package wtccr_pkg;
	// ==========================================================
	// widths
	localparam int WTCCR_AW = 6;
	localparam int WTCCR_DW = 8;
	localparam int WTCCR_CW = 12;
	// ==========================================================
	// byte offsets (low byte; high byte at offset + 1 for the 12-bit registers, debug control has none)
	localparam logic [5:0] OFS_DEBUG_CTRL = 6'h1E;
	localparam logic [5:0] OFS_CAPTURE_A = 6'h22;
	localparam logic [5:0] OFS_CAPTURE_B = 6'h24;
	localparam logic [5:0] OFS_CMP_A_SET = 6'h28;
	localparam logic [5:0] OFS_CMP_A_CLR = 6'h2A;
	localparam logic [5:0] OFS_CMP_B_SET = 6'h2C;
	localparam logic [5:0] OFS_CMP_B_CLR = 6'h2E;
	// ==========================================================
	// debug control fields
	localparam int BIT_RUN_WHILE_HALTED = 0;
	localparam int BIT_HALT_FAULT_RAISE = 2;
	localparam logic [7:0] DEBUG_CTRL_MASK = 8'h05;
	// ==========================================================
	// reset values
	localparam logic [7:0] RST_DEBUG_CTRL = 8'h00;
	localparam logic [11:0] RST_VALUE12 = 12'h000;
	// ==========================================================
	// capture slot states
	typedef enum logic [0:0] {
		CAP_OPEN = 1'b0,
		CAP_LOCKED = 1'b1
	} wtccr_cap_e;
endpackage : wtccr_pkg

// file: hw/wtccr_capture.sv
/*
 * One double-buffered capture channel: counter snapshot, second stage, read lock.
 * Assumes trigger, update and high-byte-read inputs are single-cycle pulses on the core clock.
 */
`timescale 1ns/1ps
module wtccr_capture import wtccr_pkg::*; #(
	parameter int CW = WTCCR_CW
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic trig,
	input wire logic [CW-1:0] count,
	input wire logic update,
	input wire logic hi_read,
	output logic [CW-1:0] value
);
	// ==========================================================
	// stage registers
	logic [CW-1:0] buf_q;
	logic [CW-1:0] val_q;
	logic pend_q;
	wtccr_cap_e st_q;
	wire load_second = update && pend_q && (st_q == CAP_OPEN);
	// a trigger that meets a pending unread value overwrites the first stage only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			buf_q <= CW'(RST_VALUE12);
			pend_q <= 1'b0;
		end else if (trig) begin
			buf_q <= count;
			pend_q <= 1'b1;
		end else if (load_second) begin
			pend_q <= 1'b0;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			val_q <= CW'(RST_VALUE12);
			st_q <= CAP_OPEN;
		end else begin
			case (st_q)
				CAP_OPEN: begin
					if (load_second) begin
						val_q <= buf_q;
						st_q <= CAP_LOCKED;
					end
				end
				CAP_LOCKED: begin
					if (hi_read) begin
						st_q <= CAP_OPEN;
					end
				end
				default: st_q <= CAP_OPEN;
			endcase
		end
	end
	assign value = val_q;
endmodule : wtccr_capture

// file: hw/wtccr_compare.sv
/*
 * Four-way equality comparator of set/clear values against the counter.
 * Assumes the counter is stable for the whole clock cycle.
 */
`timescale 1ns/1ps
module wtccr_compare import wtccr_pkg::*; #(
	parameter int CW = WTCCR_CW
) (
	input wire logic [CW-1:0] count,
	input wire logic [4*CW-1:0] values,
	output logic [3:0] match
);
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_cmp
			assign match[i] = (values[i*CW +: CW] == count);
		end
	endgenerate
endmodule : wtccr_compare

// file: hw/wtccr_regs.sv
/*
 * Capture/compare register set of a 12-bit waveform timer, with debug-run control.
 * Assumes a byte register port, read data one cycle after the read strobe, and an
 * external counter, trigger and update-condition source on the same clock.
 */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module wtccr_regs import wtccr_pkg::*; #(
	parameter int CW = WTCCR_CW
) (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic [WTCCR_AW-1:0] ADDR,
	input wire logic [WTCCR_DW-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [WTCCR_DW-1:0] RDATA,
	input wire logic CPU_HALTED,
	input wire logic [CW-1:0] COUNT,
	input wire logic TRIG_A,
	input wire logic TRIG_B,
	input wire logic SW_CAPTURE_A,
	input wire logic SW_CAPTURE_B,
	input wire logic UPDATE,
	output logic TIMER_RUN,
	output logic HALT_FAULT,
	output logic TRIG_FLAG_A,
	output logic TRIG_FLAG_B,
	output logic [3:0] MATCH
);
	// ==========================================================
	// elaboration check
	generate
		if (CW < 9 || CW > 16) begin : g_bad_cw
			$error("counter width must be 9 to 16");
		end
	endgenerate

	// ==========================================================
	// decode
	function automatic logic hit(input logic [5:0] a, input logic [5:0] base);
		hit = (a[5:1] == base[5:1]);
	endfunction

	logic [7:0] dbg_q;
	logic [CW-1:0] cas_q, cac_q, cbs_q, cbc_q;
	logic [7:0] rdata_q;
	logic run_q, fault_q, tfa_q, tfb_q;
	logic [3:0] match_q;
	wire [CW-1:0] cap_a, cap_b;
	wire [3:0] match_w;

	wire hi_byte = ADDR[0];
	wire w_dbg = WR && (ADDR == OFS_DEBUG_CTRL);
	wire w_cas = WR && hit(ADDR, OFS_CMP_A_SET);
	wire w_cac = WR && hit(ADDR, OFS_CMP_A_CLR);
	wire w_cbs = WR && hit(ADDR, OFS_CMP_B_SET);
	wire w_cbc = WR && hit(ADDR, OFS_CMP_B_CLR);
	wire rd_cap_a_hi = RD && (ADDR == (OFS_CAPTURE_A | 6'h01));
	wire rd_cap_b_hi = RD && (ADDR == (OFS_CAPTURE_B | 6'h01));

	// ==========================================================
	// debug run gating
	wire halted_stop = CPU_HALTED && !dbg_q[BIT_RUN_WHILE_HALTED];
	wire timer_en = !halted_stop;
	wire cap_trig_a = timer_en && (TRIG_A || SW_CAPTURE_A);
	wire cap_trig_b = timer_en && (TRIG_B || SW_CAPTURE_B);
	wire upd_en = timer_en && UPDATE;
	wire fault_now = halted_stop && dbg_q[BIT_HALT_FAULT_RAISE];

	// upper bits beyond the counter width are never stored
	function automatic logic [CW-1:0] merge(input logic [CW-1:0] old, input logic hi,
		input logic [7:0] d);
		logic [15:0] w;
		w = 16'(old);
		if (hi)
			w[15:8] = d;
		else
			w[7:0] = d;
		merge = w[CW-1:0];
	endfunction

	function automatic logic [7:0] pick(input logic [CW-1:0] v, input logic hi);
		logic [15:0] w;
		w = 16'(v);
		pick = hi ? w[15:8] : w[7:0];
	endfunction

	// ==========================================================
	// registers
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			dbg_q <= RST_DEBUG_CTRL;
		end else if (w_dbg) begin
			dbg_q <= WDATA & DEBUG_CTRL_MASK;
		end
	end

	// each byte lands on its own; no high-byte latch, so a 12-bit update takes two writes
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			cas_q <= CW'(RST_VALUE12);
		end else if (w_cas) begin
			cas_q <= merge(cas_q, hi_byte, WDATA);
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			cac_q <= CW'(RST_VALUE12);
		end else if (w_cac) begin
			cac_q <= merge(cac_q, hi_byte, WDATA);
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			cbs_q <= CW'(RST_VALUE12);
		end else if (w_cbs) begin
			cbs_q <= merge(cbs_q, hi_byte, WDATA);
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			cbc_q <= CW'(RST_VALUE12);
		end else if (w_cbc) begin
			cbc_q <= merge(cbc_q, hi_byte, WDATA);
		end
	end

	// ==========================================================
	// read mux; unmapped offsets read zero
	wire [7:0] rd_mux =
		(ADDR == OFS_DEBUG_CTRL) ? dbg_q :
		hit(ADDR, OFS_CAPTURE_A) ? pick(cap_a, hi_byte) :
		hit(ADDR, OFS_CAPTURE_B) ? pick(cap_b, hi_byte) :
		hit(ADDR, OFS_CMP_A_SET) ? pick(cas_q, hi_byte) :
		hit(ADDR, OFS_CMP_A_CLR) ? pick(cac_q, hi_byte) :
		hit(ADDR, OFS_CMP_B_SET) ? pick(cbs_q, hi_byte) :
		hit(ADDR, OFS_CMP_B_CLR) ? pick(cbc_q, hi_byte) : 8'h00;

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= RD ? rd_mux : 8'h00;
		end
	end

	// ==========================================================
	// capture channels
	wtccr_capture #(.CW(CW)) u_cap_a (
		.clk(CORE_CLK),
		.rst_n(RESETN),
		.trig(cap_trig_a),
		.count(COUNT),
		.update(upd_en),
		.hi_read(rd_cap_a_hi),
		.value(cap_a)
	);

	wtccr_capture #(.CW(CW)) u_cap_b (
		.clk(CORE_CLK),
		.rst_n(RESETN),
		.trig(cap_trig_b),
		.count(COUNT),
		.update(upd_en),
		.hi_read(rd_cap_b_hi),
		.value(cap_b)
	);

	// ==========================================================
	// comparators; match order: a set, a clear, b set, b clear
	wtccr_compare #(.CW(CW)) u_cmp (
		.count(COUNT),
		.values({cbc_q, cbs_q, cac_q, cas_q}),
		.match(match_w)
	);

	// outputs registered; matches are one cycle late, which the waveform logic must allow for
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			run_q <= 1'b0;
		end else begin
			run_q <= timer_en;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			fault_q <= 1'b0;
		end else begin
			fault_q <= fault_now;
		end
	end

	// flags pulse each cycle the cause holds; the sticky flags live in the waveform logic
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			tfa_q <= 1'b0;
			tfb_q <= 1'b0;
		end else begin
			tfa_q <= fault_now || cap_trig_a;
			tfb_q <= fault_now || cap_trig_b;
		end
	end

	// gated while stopped so a frozen counter cannot keep firing a match
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			match_q <= 4'h0;
		end else begin
			match_q <= timer_en ? match_w : 4'h0;
		end
	end

	assign RDATA = rdata_q;
	assign TIMER_RUN = run_q;
	assign HALT_FAULT = fault_q;
	assign TRIG_FLAG_A = tfa_q;
	assign TRIG_FLAG_B = tfb_q;
	assign MATCH = match_q;
endmodule : wtccr_regs

// file: testbench/wtccr_chk.sv
/*
 * Port checker for the waveform timer capture/compare register block.
 * Assumes one core clock and bind onto wtccr_regs.
 */
`timescale 1ns/1ps
module wtccr_chk import wtccr_pkg::*; (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic [WTCCR_AW-1:0] ADDR,
	input wire logic RD,
	input wire logic [WTCCR_DW-1:0] RDATA,
	input wire logic CPU_HALTED,
	input wire logic TRIG_A,
	input wire logic TRIG_B,
	input wire logic SW_CAPTURE_A,
	input wire logic SW_CAPTURE_B,
	input wire logic TIMER_RUN,
	input wire logic HALT_FAULT,
	input wire logic TRIG_FLAG_A,
	input wire logic TRIG_FLAG_B,
	input wire logic [3:0] MATCH
);
	// ==========================================================
	// assertions
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	property p_rd_idle; !$past(RD) |-> RDATA == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_hi_zero; $past(RD && ADDR[0]) |-> RDATA[7:4] == 4'h0; endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("upper nibble not zero");
	property p_gap; $past(RD) && $past(ADDR) == 6'h26 |-> RDATA == 8'h00; endproperty
	a_gap: assert property (p_gap) else $error("unmapped read not zero");
	property p_run; $past(RESETN) && !$past(CPU_HALTED) |-> TIMER_RUN; endproperty
	a_run: assert property (p_run) else $error("timer stopped while cpu runs");
	property p_stop; !TIMER_RUN |-> MATCH == 4'h0; endproperty
	a_stop: assert property (p_stop) else $error("match while stopped");
	property p_flt; HALT_FAULT |-> $past(CPU_HALTED) && TRIG_FLAG_A && TRIG_FLAG_B; endproperty
	a_flt: assert property (p_flt) else $error("fault without halt or flags");
	property p_fa; TRIG_FLAG_A && !HALT_FAULT |-> $past(TRIG_A || SW_CAPTURE_A); endproperty
	a_fa: assert property (p_fa) else $error("flag a without cause");
	property p_fb; TRIG_FLAG_B && !HALT_FAULT |-> $past(TRIG_B || SW_CAPTURE_B); endproperty
	a_fb: assert property (p_fb) else $error("flag b without cause");
endmodule : wtccr_chk

bind wtccr_regs wtccr_chk u_chk (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .ADDR(ADDR), .RD(RD),
	.RDATA(RDATA), .CPU_HALTED(CPU_HALTED), .TRIG_A(TRIG_A), .TRIG_B(TRIG_B),
	.SW_CAPTURE_A(SW_CAPTURE_A), .SW_CAPTURE_B(SW_CAPTURE_B), .TIMER_RUN(TIMER_RUN),
	.HALT_FAULT(HALT_FAULT), .TRIG_FLAG_A(TRIG_FLAG_A), .TRIG_FLAG_B(TRIG_FLAG_B),
	.MATCH(MATCH));

// file: testbench/tb_wtccr_regs.sv
/*
 * Self-checking bench for the capture/compare register block.
 * Assumes the bench alone drives every port; counter and events are stimulus.
 */
`timescale 1ns/1ps
module tb_wtccr_regs import wtccr_pkg::*; ;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, halted = 0;
	logic [5:0] addr = 0;
	logic [7:0] wd = 0, d;
	logic [11:0] cnt = 0, last_a;
	logic [4:0] ev = 0;
	wire [7:0] rdata;
	wire run, flt, fa, fb;
	wire [3:0] match;
	int err_total = 0, check_count = 0, cyc = 0;
	wtccr_regs u_dut (.CORE_CLK(clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wd), .WR(wr),
		.RD(rd), .RDATA(rdata), .CPU_HALTED(halted), .COUNT(cnt), .TRIG_A(ev[0]),
		.TRIG_B(ev[1]), .SW_CAPTURE_A(ev[2]), .SW_CAPTURE_B(ev[3]), .UPDATE(ev[4]),
		.TIMER_RUN(run), .HALT_FAULT(flt), .TRIG_FLAG_A(fa), .TRIG_FLAG_B(fb), .MATCH(match));
	// ==========================================================
	// helpers
	function automatic logic [11:0] cv(int i);
		return 12'(12'h123 + 12'h111 * i);
	endfunction : cv
	task automatic chk(string n, logic [11:0] s, logic [11:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wrb(logic [5:0] a, logic [7:0] v);
		@(posedge clk) begin addr <= a; wd <= v; wr <= 1; end
		@(posedge clk) wr <= 0;
	endtask : wrb
	task automatic rdb(logic [5:0] a, output logic [7:0] v);
		@(posedge clk) begin addr <= a; rd <= 1; end
		@(posedge clk) rd <= 0;
		#1 v = rdata;
	endtask : rdb
	task automatic rdw(logic [5:0] a, output logic [11:0] v);
		logic [7:0] lo, hi;
		rdb(a, lo);
		rdb(a + 6'h01, hi);
		v = {hi[3:0], lo};
		chk("upper nibble", {8'h00, hi[7:4]}, 12'h000);
	endtask : rdw
	task automatic pulse(int b);
		@(posedge clk) ev[b] <= 1;
		@(posedge clk) ev[b] <= 0;
	endtask : pulse
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	// ==========================================================
	// scenarios
	task automatic t_reset();
		for (int a = 6'h1E; a < 6'h30; a++) begin
			rdb(a[5:0], d);
			chk("reset value", {4'h0, d}, 12'h000);
		end
	endtask : t_reset
	task automatic t_rw();
		logic [11:0] v;
		wrb(6'h22, 8'h55);
		wrb(6'h25, 8'h0F);
		for (int i = 0; i < 4; i++) begin
			v = cv(i);
			wrb(6'(6'h28 + 2 * i), v[7:0]);
			wrb(6'(6'h29 + 2 * i), {4'hF, v[11:8]});
		end
		for (int i = 0; i < 4; i++) begin
			rdw(6'(6'h28 + 2 * i), v);
			chk("compare value", v, cv(i));
		end
		rdw(6'h22, v);
		chk("capture a write", v, 12'h000);
		rdw(6'h24, v);
		chk("capture b write", v, 12'h000);
	endtask : t_rw
	task automatic t_match();
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) cnt <= cv(i);
			settle();
			chk("match", {8'h00, match}, 12'h001 << i);
		end
	endtask : t_match
	task automatic t_cap(int ch, int sw);
		logic [11:0] v, v1, v2;
		v1 = 12'(12'h9A5 + 12'h010 * ch + sw);
		v2 = ~v1;
		@(posedge clk) cnt <= v1;
		pulse(ch + 2 * sw);
		pulse(4);
		@(posedge clk) cnt <= v2;
		pulse(ch + 2 * sw);
		pulse(4);
		rdw(6'(6'h22 + 2 * ch), v);
		chk("capture held", v, v1);
		pulse(4);
		rdw(6'(6'h22 + 2 * ch), v);
		chk("capture released", v, v2);
		if (ch == 0) last_a = v2;
	endtask : t_cap
	task automatic t_debug();
		logic [11:0] v;
		@(posedge clk) halted <= 1;
		settle();
		chk("stopped", {11'h000, run}, 12'h000);
		@(posedge clk) cnt <= 12'h777;
		pulse(0);
		pulse(4);
		rdw(6'h22, v);
		chk("event ignored", v, last_a);
		wrb(6'h1E, 8'h01);
		settle();
		chk("debug run", {11'h000, run}, 12'h001);
		@(posedge clk) cnt <= 12'h321;
		pulse(0);
		pulse(4);
		rdw(6'h22, v);
		chk("capture while halted", v, 12'h321);
		wrb(6'h1E, 8'hFE);
		rdb(6'h1E, d);
		chk("debug ctrl", {4'h0, d}, 12'h004);
		settle();
		chk("fault flags", {9'h000, flt, fa, fb}, 12'h007);
		@(posedge clk) halted <= 0;
		wrb(6'h1E, 8'h00);
	endtask : t_debug
	// ==========================================================
	// run control
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			stop_test();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1;
		t_reset();
		t_rw();
		t_match();
		for (int k = 0; k < 4; k++) t_cap(k % 2, k / 2);
		t_debug();
		stop_test();
	end
endmodule : tb_wtccr_regs
